//--- pkg/auto_restart_params.svh
`ifndef AUTO_RESTART_PARAMS_SVH
`define AUTO_RESTART_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define AR_CFG_OFS 8'h00
`define AR_DELAY_OFS 8'h04
`define AR_STATUS_OFS 8'h08
`define AR_CMD_OFS 8'h0c

////////////////////////////////////////////////////////////////////////////
// Field positions
`define AR_CFG_LIMIT_LSB 0
`define AR_CFG_SELECT_LSB 8
`define AR_CFG_CURLIM_LSB 16
`define AR_ST_REMAIN_LSB 0
`define AR_ST_INHIBIT_BIT 8
`define AR_ST_SEARCH_BIT 9
`define AR_ST_HOLD_BIT 10
`define AR_ST_LOCKED_BIT 11
`define AR_ST_HALTED_BIT 12
`define AR_ST_STATE_LSB 16
`define AR_CMD_RESET_BIT 0

////////////////////////////////////////////////////////////////////////////
// Reset values and limits
`define AR_LIMIT_RESET 4'h0
`define AR_LIMIT_MAX 4'ha
`define AR_SELECT_RESET 4'h0
`define AR_CURLIM_RESET 8'h64
`define AR_CURLIM_MIN 8'h50
`define AR_CURLIM_MAX 8'hc8
`define AR_DELAY_RESET 10'h00a
`define AR_DELAY_MAX 10'h258

////////////////////////////////////////////////////////////////////////////
// Timing: clock rate, tick period, quiet period
`define AR_SYS_CLK_HZ 250000000
`define AR_TICK_PERIOD_MS 100
`define AR_TICK_CYCLES (`AR_SYS_CLK_HZ / 1000 * `AR_TICK_PERIOD_MS)
`define AR_QUIET_TIME_S 30
`define AR_QUIET_TICKS (`AR_QUIET_TIME_S * 1000 / `AR_TICK_PERIOD_MS)

`endif

//--- pkg/auto_restart_pkg.sv
package auto_restart_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_SEARCH,
    ST_WATCH,
    ST_LOCKED,
    ST_HALTED
  } seq_state_t;

  // Whole state of the sequencer and its register slave
  typedef struct packed {
    seq_state_t st;
    logic awready;
    logic aw_held;
    logic [7:0] awaddr;
    logic wready;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] try_limit;
    logic [3:0] ss_select;
    logic [7:0] cur_limit;
    logic [9:0] delay;
    logic [3:0] remaining;
    logic [9:0] timer;
    logic tick_clr;
    logic es1;
    logic es2;
    logic fr1;
    logic fr2;
    logic fr3;
    logic inhibit;
    logic restart_pulse;
    logic search_active;
    logic hold_voltage;
  } seq_regs_t;

endpackage : auto_restart_pkg

//--- rtl/fault_auto_restart_control.sv
// Summary of operation
// (R1) Software sets an attempt limit of 0 to 10, which resets to 0.
// (R2) After a trip the restart waits a delay of 0 to 60 s, default 1.0 s.
// (R3) Each restart carried out lowers the remaining attempts by one.
// (R4) A trip with no attempts left locks the restart out and stays stopped.
// (R5) A terminal or keypad fault reset reloads attempts from the limit.
// (R6) Thirty seconds without a trip after a restart reloads the attempts.
// (R7) Low-voltage trips and emergency stop never lead to a restart.
// (R8) When the delay expires the motor restarts through speed search.
// (R9) In search, current over the limit holds voltage and lowers frequency.
// (R10) Output stays inhibited until the delay expires; limit 0 disables.
`timescale 1ns/100ps
`default_nettype none
`include "auto_restart_params.svh"

module fault_auto_restart_control #(
  parameter int unsigned TICK_CYCLES = `AR_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Trip protection, same clock
  input wire logic trip_event,
  input wire logic trip_low_voltage,
  // Pins from the terminal block and keypad
  input wire logic emergency_stop_input,
  input wire logic fault_reset_input,
  // Motor output stage, same clock
  input wire logic [7:0] output_current_pct,
  input wire logic search_done,
  // Toward output stage and acceleration control
  output logic output_inhibit,
  output logic restart_start,
  output logic speed_search_active,
  output logic search_hold_voltage,
  output logic [3:0] speed_search_select
);

  localparam logic [9:0] QUIET_TICKS = 10'(`AR_QUIET_TICKS);

  auto_restart_pkg::seq_regs_t r_reg;
  auto_restart_pkg::seq_regs_t r_next;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // Tenth-of-second time base
  tenth_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .clr(r_reg.tick_clr),
    .tick(tick)
  );

  // Merge write data into a word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [31:0] cfg_word;
    logic [31:0] wr_word;
    logic [31:0] status_word;
    logic sw_reset;
    logic fault_reset;
    logic halted;
    cfg_word = 32'h0000_0000;
    wr_word = 32'h0000_0000;
    status_word = 32'h0000_0000;
    sw_reset = 1'b0;
    fault_reset = 1'b0;
    halted = 1'b0;
    r_next = r_reg;
    r_next.restart_pulse = 1'b0;
    r_next.tick_clr = 1'b0;

    // Pin synchronisers; the third stage only feeds the edge detector
    r_next.es1 = emergency_stop_input;
    r_next.es2 = r_reg.es1;
    r_next.fr1 = fault_reset_input;
    r_next.fr2 = r_reg.fr1;
    r_next.fr3 = r_reg.fr2;

    cfg_word[`AR_CFG_LIMIT_LSB +: 4] = r_reg.try_limit;
    cfg_word[`AR_CFG_SELECT_LSB +: 4] = r_reg.ss_select;
    cfg_word[`AR_CFG_CURLIM_LSB +: 8] = r_reg.cur_limit;
    status_word[`AR_ST_REMAIN_LSB +: 4] = r_reg.remaining;
    status_word[`AR_ST_INHIBIT_BIT] = r_reg.inhibit;
    status_word[`AR_ST_SEARCH_BIT] = r_reg.search_active;
    status_word[`AR_ST_HOLD_BIT] = r_reg.hold_voltage;
    status_word[`AR_ST_LOCKED_BIT] = (r_reg.st == auto_restart_pkg::ST_LOCKED);
    status_word[`AR_ST_HALTED_BIT] = (r_reg.st == auto_restart_pkg::ST_HALTED);
    status_word[`AR_ST_STATE_LSB +: 3] = r_reg.st;

    // Write address and data are taken independently
    if (s_axi_awvalid && r_reg.awready)
    begin
      r_next.aw_held = 1'b1;
      r_next.awaddr = s_axi_awaddr;
      r_next.awready = 1'b0;
    end
    if (s_axi_wvalid && r_reg.wready)
    begin
      r_next.w_held = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
      r_next.wready = 1'b0;
    end

    // Perform the write once both halves are held
    if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid)
    begin
      r_next.aw_held = 1'b0;
      r_next.w_held = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = 2'h0;
      case (r_reg.awaddr)
        `AR_CFG_OFS:
        begin
          wr_word = merge(cfg_word, r_reg.wdata, r_reg.wstrb);
          r_next.try_limit = wr_word[`AR_CFG_LIMIT_LSB +: 4]; // R1
          if (wr_word[`AR_CFG_LIMIT_LSB +: 4] > `AR_LIMIT_MAX)
          begin
            r_next.try_limit = `AR_LIMIT_MAX; // R1
          end
          r_next.ss_select = wr_word[`AR_CFG_SELECT_LSB +: 4];
          r_next.cur_limit = wr_word[`AR_CFG_CURLIM_LSB +: 8];
          if (wr_word[`AR_CFG_CURLIM_LSB +: 8] < `AR_CURLIM_MIN)
          begin
            r_next.cur_limit = `AR_CURLIM_MIN;
          end
          else if (wr_word[`AR_CFG_CURLIM_LSB +: 8] > `AR_CURLIM_MAX)
          begin
            r_next.cur_limit = `AR_CURLIM_MAX;
          end
        end
        `AR_DELAY_OFS:
        begin
          wr_word = merge({22'h000000, r_reg.delay}, r_reg.wdata,
                          r_reg.wstrb);
          r_next.delay = wr_word[9:0]; // R2
          if (wr_word[31:0] > {22'h000000, `AR_DELAY_MAX})
          begin
            r_next.delay = `AR_DELAY_MAX; // R2
          end
        end
        `AR_STATUS_OFS:
        begin
          r_next.bresp = 2'h0; // Read-only, write ignored
        end
        `AR_CMD_OFS:
        begin
          sw_reset = r_reg.wstrb[0] && r_reg.wdata[`AR_CMD_RESET_BIT];
        end
        default:
        begin
          r_next.bresp = 2'h2;
        end
      endcase
    end
    if (r_reg.bvalid && s_axi_bready)
    begin
      r_next.bvalid = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready = 1'b1;
    end

    // Read channel: one outstanding read
    if (s_axi_arvalid && r_reg.arready)
    begin
      r_next.arready = 1'b0;
      r_next.rvalid = 1'b1;
      r_next.rresp = 2'h0;
      case (s_axi_araddr)
        `AR_CFG_OFS: r_next.rdata = cfg_word;
        `AR_DELAY_OFS: r_next.rdata = {22'h000000, r_reg.delay};
        `AR_STATUS_OFS: r_next.rdata = status_word;
        `AR_CMD_OFS: r_next.rdata = 32'h0000_0000;
        default:
        begin
          r_next.rdata = 32'h0000_0000;
          r_next.rresp = 2'h2;
        end
      endcase
    end
    if (r_reg.rvalid && s_axi_rready)
    begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end

    fault_reset = (r_reg.fr2 && !r_reg.fr3) || sw_reset;

    // Restart sequencer
    case (r_reg.st)
      auto_restart_pkg::ST_RUN:
      begin
        if (trip_event)
        begin
          if (trip_low_voltage)
          begin
            r_next.st = auto_restart_pkg::ST_HALTED; // R7
          end
          else if (r_reg.remaining == 4'h0)
          begin
            r_next.st = auto_restart_pkg::ST_LOCKED; // R4 R10
          end
          else
          begin
            r_next.st = auto_restart_pkg::ST_WAIT; // R2
            r_next.timer = r_reg.delay;
            r_next.tick_clr = 1'b1;
          end
        end
      end
      auto_restart_pkg::ST_WAIT:
      begin
        if (r_reg.timer == 10'h000)
        begin
          r_next.st = auto_restart_pkg::ST_SEARCH; // R8
          r_next.remaining = r_reg.remaining - 4'h1; // R3
          r_next.restart_pulse = 1'b1; // R8
        end
        else if (tick && !r_reg.tick_clr) // Skip a tick from before clear
        begin
          r_next.timer = r_reg.timer - 10'h001; // R2
        end
      end
      auto_restart_pkg::ST_SEARCH, auto_restart_pkg::ST_WATCH:
      begin
        if (trip_event)
        begin
          if (trip_low_voltage)
          begin
            r_next.st = auto_restart_pkg::ST_HALTED; // R7
          end
          else if (r_reg.remaining == 4'h0)
          begin
            r_next.st = auto_restart_pkg::ST_LOCKED; // R4
          end
          else
          begin
            r_next.st = auto_restart_pkg::ST_WAIT; // R2
            r_next.timer = r_reg.delay;
            r_next.tick_clr = 1'b1;
          end
        end
        else if (r_reg.st == auto_restart_pkg::ST_SEARCH)
        begin
          if (search_done)
          begin
            r_next.st = auto_restart_pkg::ST_WATCH;
            r_next.timer = QUIET_TICKS; // R6
            r_next.tick_clr = 1'b1;
          end
        end
        else if (tick && !r_reg.tick_clr) // Skip a tick from before clear
        begin
          r_next.timer = r_reg.timer - 10'h001;
          if (r_reg.timer == 10'h001)
          begin
            r_next.st = auto_restart_pkg::ST_RUN;
            r_next.remaining = r_reg.try_limit; // R6
          end
        end
      end
      auto_restart_pkg::ST_LOCKED, auto_restart_pkg::ST_HALTED:
      begin
        r_next.st = r_reg.st; // Held until a fault reset
      end
      default:
      begin
        r_next.st = auto_restart_pkg::ST_HALTED;
      end
    endcase

    // A manual reset reloads attempts and returns to normal running; under emergency stop only a software reset acts, reloading attempts alone
    if (fault_reset && !r_reg.es2)
    begin
      r_next.remaining = r_reg.try_limit; // R5
      r_next.st = auto_restart_pkg::ST_RUN;
      r_next.restart_pulse = 1'b0;
    end
    else if (sw_reset)
    begin
      r_next.remaining = r_reg.try_limit; // R5
    end

    // New limit takes effect at once while running normally
    if (r_reg.aw_held && r_reg.w_held && !r_reg.bvalid &&
        r_reg.awaddr == `AR_CFG_OFS && r_next.st == auto_restart_pkg::ST_RUN)
    begin
      r_next.remaining = r_next.try_limit;
    end

    // Emergency stop overrides the sequencer state and blocks restart
    if (r_reg.es2)
    begin
      r_next.st = auto_restart_pkg::ST_HALTED; // R7
      r_next.restart_pulse = 1'b0;
    end

    halted = (r_next.st == auto_restart_pkg::ST_WAIT) ||
             (r_next.st == auto_restart_pkg::ST_LOCKED) ||
             (r_next.st == auto_restart_pkg::ST_HALTED);
    r_next.inhibit = halted; // R10
    r_next.search_active = (r_next.st == auto_restart_pkg::ST_SEARCH); // R8
    r_next.hold_voltage = r_next.search_active &&
                          (output_current_pct > r_reg.cur_limit); // R9
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      r_reg <= '0;
      r_reg.st <= auto_restart_pkg::ST_RUN;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
      r_reg.try_limit <= `AR_LIMIT_RESET; // R1
      r_reg.ss_select <= `AR_SELECT_RESET;
      r_reg.cur_limit <= `AR_CURLIM_RESET;
      r_reg.delay <= `AR_DELAY_RESET; // R2
      r_reg.remaining <= `AR_LIMIT_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign output_inhibit = r_reg.inhibit;
  assign restart_start = r_reg.restart_pulse;
  assign speed_search_active = r_reg.search_active;
  assign search_hold_voltage = r_reg.hold_voltage;
  assign speed_search_select = r_reg.ss_select;

endmodule : fault_auto_restart_control

`default_nettype wire

//--- rtl/tenth_tick.sv
`timescale 1ns/100ps
`default_nettype none
`include "auto_restart_params.svh"

module tenth_tick #(
  parameter int unsigned TICK_CYCLES = `AR_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Restart of the period
  input wire logic clr,
  // One-cycle pulse per period
  output logic tick
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic tick_reg;
  logic tick_next;

  // Count the period; a clear restarts it from zero
  always_comb
  begin
    count_next = count_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (clr)
    begin
      count_next = 32'h0000_0000;
    end
    else if (count_reg >= 32'(TICK_CYCLES - 1))
    begin
      count_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      count_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : tenth_tick

`default_nettype wire

//--- test/drive_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module drive_stage_model (
  // Clock
  input wire logic sys_clk,
  // Commands from the bench
  input wire logic trip_req,
  input wire logic lv_req,
  // From the sequencer
  input wire logic speed_search_active,
  // Toward the sequencer
  output logic trip_event,
  output logic trip_low_voltage,
  output logic [7:0] output_current_pct,
  output logic search_done
);
  logic [4:0] srch_cnt;
  // Quiet drive at time zero
  initial
  begin
    srch_cnt = 5'h00;
    trip_event = 1'b0;
    trip_low_voltage = 1'b0;
    output_current_pct = 8'h3c;
    search_done = 1'b0;
  end
  // Trips on request; search draws high current first, ends after 13
  always @(posedge sys_clk)
  begin
    trip_event <= trip_req;
    trip_low_voltage <= lv_req;
    srch_cnt <= speed_search_active ? srch_cnt + 5'h01 : 5'h00;
    search_done <= speed_search_active && srch_cnt == 5'h0c;
    output_current_pct <= (speed_search_active && srch_cnt < 5'h06) ?
      8'h78 : 8'h3c;
  end
endmodule : drive_stage_model
`default_nettype wire

//--- test/fault_auto_restart_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fault_auto_restart_control_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic emergency_stop_input = 1'b0;
  logic fault_reset_input = 1'b0;
  logic trip_req = 1'b0;
  logic lv_req = 1'b0;
  logic hold_seen = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, trip_event, trip_low_voltage, search_done;
  logic output_inhibit, restart_start, speed_search_active;
  logic search_hold_voltage;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] output_current_pct;
  logic [3:0] speed_search_select;
  int err_count = 0;
  int checked = 0;
  int n;

  fault_auto_restart_control #(.TICK_CYCLES(4))
    u_fault_auto_restart_control (.sys_clk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .trip_event, .trip_low_voltage, .emergency_stop_input,
    .fault_reset_input, .output_current_pct, .search_done,
    .output_inhibit, .restart_start, .speed_search_active,
    .search_hold_voltage, .speed_search_select);
  drive_stage_model u_drive_stage_model (.sys_clk, .trip_req, .lv_req,
    .speed_search_active, .trip_event, .trip_low_voltage,
    .output_current_pct, .search_done);

  ////////////////////////////////////////////////////////////////////////
  // Clock and voltage-hold monitor
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (search_hold_voltage) hold_seen <= 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic hang(input int k);
    if (k >= 200)
    begin
      err_count++;
      $display("wrong value handshake expected answer seen none");
      stop_test();
    end
  endtask : hang

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw, w, b;
    int k;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (b && k < 200)
    begin
      @(posedge sys_clk);
      k++;
      // Release each valid once taken; bready stays high between writes
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        b = 1'b0;
      end
    end
    hang(k);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && k < 200);
    hang(k);
    cmp($sformatf("rdata_%h", a), e, s_axi_rdata & m);
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : axi_rd

  task automatic trip(input logic lv);
    trip_req <= 1'b1;
    lv_req <= lv;
    @(posedge sys_clk);
    trip_req <= 1'b0;
    lv_req <= 1'b0;
    @(posedge sys_clk);
  endtask : trip

  task automatic wait_rs(input int lim);
    n = 0;
    while (!restart_start && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_rs

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    axi_rd(8'h00, 32'h00ff0f0f, 32'h00640000, 2'h0);
    axi_rd(8'h04, 32'h3ff, 32'h00a, 2'h0);
    axi_rd(8'h08, 32'h7000f, 32'h0, 2'h0);
    axi_rd(8'h10, 32'hffffffff, 32'h0, 2'h2);
    axi_wr(8'h10, 32'h1, 2'h2);
    $display("test reset_values done");
    trip(1'b0);
    wait_rs(60);
    cmp("no_restart", 32'd60, n);
    axi_rd(8'h08, 32'h800, 32'h800, 2'h0);
    fault_reset_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fault_reset_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    axi_rd(8'h08, 32'h70800, 32'h0, 2'h0);
    $display("test limit_zero done");
    axi_wr(8'h00, 32'h0050050f, 2'h0);
    axi_rd(8'h00, 32'h00ff0f0f, 32'h0050050a, 2'h0);
    cmp("select", 32'h5, {28'h0, speed_search_select});
    axi_wr(8'h00, 32'h00500502, 2'h0);
    axi_wr(8'h04, 32'h3, 2'h0);
    trip(1'b0);
    wait_rs(40);
    cmp("delay_ok", 32'h1, {31'h0, n >= 12 && n <= 16});
    axi_rd(8'h08, 32'hf, 32'h1, 2'h0);
    repeat (20) @(posedge sys_clk);
    cmp("hold_seen", 32'h1, {31'h0, hold_seen});
    cmp("hold_end", 32'h0, {31'h0, search_hold_voltage});
    trip(1'b0);
    wait_rs(40);
    cmp("restart", 32'h1, {31'h0, restart_start});
    cmp("search_active", 32'h1, {31'h0, speed_search_active});
    axi_rd(8'h08, 32'hf, 32'h0, 2'h0);
    repeat (20) @(posedge sys_clk);
    trip(1'b0);
    wait_rs(60);
    cmp("no_restart", 32'd60, n);
    axi_wr(8'h0c, 32'h1, 2'h0);
    axi_rd(8'h08, 32'h7000f, 32'h2, 2'h0);
    $display("test attempt_count done");
    trip(1'b0);
    wait_rs(40);
    cmp("restart", 32'h1, {31'h0, restart_start});
    repeat (1150) @(posedge sys_clk);
    axi_rd(8'h08, 32'hf, 32'h1, 2'h0);
    repeat (100) @(posedge sys_clk);
    axi_rd(8'h08, 32'hf, 32'h2, 2'h0);
    $display("test quiet_period done");
    trip(1'b1);
    wait_rs(60);
    cmp("no_restart", 32'd60, n);
    axi_rd(8'h08, 32'h1000, 32'h1000, 2'h0);
    axi_wr(8'h0c, 32'h1, 2'h0);
    emergency_stop_input <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cmp("inhibit", 32'h1, {31'h0, output_inhibit});
    trip(1'b0);
    wait_rs(60);
    cmp("no_restart", 32'd60, n);
    emergency_stop_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    axi_wr(8'h0c, 32'h1, 2'h0);
    axi_rd(8'h08, 32'h70000, 32'h0, 2'h0);
    $display("test halt_cases done");
    stop_test();
  end
endmodule : fault_auto_restart_control_tb
`default_nettype wire

//--- test/restart_checks_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module restart_checks (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Sequencer
  input wire logic trip_event,
  input wire logic trip_low_voltage,
  input wire logic emergency_stop_input,
  input wire logic output_inhibit,
  input wire logic restart_start,
  input wire logic speed_search_active,
  input wire logic search_hold_voltage,
  input wire logic [3:0] speed_search_select
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  chk_restart_pulse: assert property (restart_start |=> !restart_start)
    else $error("restart pulse too long");
  chk_restart_search: assert property (
    restart_start |-> !output_inhibit && speed_search_active)
    else $error("restart without search or with inhibit");
  chk_wait_before: assert property (
    $rose(restart_start) |-> $past(output_inhibit))
    else $error("restart without preceding wait");
  chk_trip_inhibit: assert property (trip_event && !trip_low_voltage &&
    !output_inhibit && !emergency_stop_input |=> output_inhibit)
    else $error("trip did not inhibit output");
  chk_lv_no_restart: assert property (trip_event && trip_low_voltage &&
    !output_inhibit |=> !restart_start [*8])
    else $error("restart after low-voltage trip");
  chk_estop_halt: assert property (emergency_stop_input [*5] |->
    output_inhibit && !restart_start)
    else $error("emergency stop did not halt");
  chk_hold_search: assert property (search_hold_voltage |->
    speed_search_active || $past(speed_search_active))
    else $error("voltage hold outside search");
  chk_select_write: assert property ($changed(speed_search_select) |->
    $rose(s_axi_bvalid))
    else $error("select changed without write");
  ////////////////////////////////////////////////////////////////////////
  // Register bus
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles");
endmodule : restart_checks

bind fault_auto_restart_control restart_checks u_restart_checks (
  .sys_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .trip_event, .trip_low_voltage, .emergency_stop_input,
  .output_inhibit, .restart_start, .speed_search_active,
  .search_hold_voltage, .speed_search_select);
`default_nettype wire
